// ===== hdl/start_profile_seq.sv
// Purpose: start profile sequencer with AXI4-Lite register file
// Assumes: full_speed_in and select_n_in are asynchronous contacts; sense_in is on aclk
// Notes:   out_level is percent of full output; meaning depends on out_mode
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
module start_profile_seq
    import start_seq_pkg::*;
#(
    parameter int          TENTH_CYC   = TENTH_CYCLES,
    parameter logic [7:0]  OPTION_CODE = 8'h01   // arbitrary value
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    // axi4-lite write data
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // axi4-lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi4-lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // motor side
    input  wire logic        full_speed_in,
    input  wire logic        select_n_in,
    input  wire logic [11:0] sense_in,
    output logic [9:0]       out_level,
    output start_mode_e      out_mode,
    output logic             kick_active,
    output logic             full_voltage,
    output logic             running
);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic prof_s prof_wr(input prof_s old, input logic [31:0] d);
        prof_s p;
        p.mode   = start_mode_e'(d[PROF_MODE_LSB +: 2]);
        p.ramp_s = (d[PROF_RAMP_LSB +: 5] > RAMP_MAX_S) ? RAMP_MAX_S : d[PROF_RAMP_LSB +: 5];
        if (p.mode == MODE_SOFT) begin
            p.torque = (d[PROF_TORQ_LSB +: 7] > TORQ_MAX_PCT) ? TORQ_MAX_PCT : d[PROF_TORQ_LSB +: 7];
        end else begin
            p.torque = old.torque;
        end
        return p;
    endfunction

    function automatic logic [31:0] prof_rd(input prof_s p);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[PROF_MODE_LSB +: 2] = p.mode;
        r[PROF_RAMP_LSB +: 5] = p.ramp_s;
        if (p.mode == MODE_SOFT) begin
            r[PROF_TORQ_LSB +: 7] = p.torque;
        end
        return r;
    endfunction

    // widened so level times tenths cannot wrap before the divide
    function automatic logic [9:0] ramp_part(input logic [9:0] a, input logic [8:0] n, input logic [8:0] d);
        logic [18:0] p;
        p = {9'h000, a} * {10'h000, n};
        return 10'(p / {10'h000, d});
    endfunction

    // pin synchronisers
    logic [1:0] fs_sync_r;
    logic [1:0] sel_sync_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_sync_r  <= 2'h0;
            sel_sync_r <= 2'h3;
        end else begin
            fs_sync_r  <= {fs_sync_r[0], full_speed_in};
            sel_sync_r <= {sel_sync_r[0], select_n_in};
        end
    end
    logic full_speed;
    logic select_hi;
    assign full_speed = fs_sync_r[1];
    assign select_hi  = sel_sync_r[1];

    // register file and axi slave state
    prof_s       prof1_r, prof1_nxt, prof2_r, prof2_nxt;
    kick_s       kick_r, kick_nxt;
    logic [9:0]  clim_r, clim_nxt;
    logic [13:0] scale_r, scale_nxt;
    logic        dual_r, dual_nxt;
    logic        start_r, start_nxt, stop_r, stop_nxt;
    logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0]  awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [25:0] line_r, line_nxt;

    // sequencer state
    seq_state_e  state_r, state_nxt;
    prof_s       act_r, act_nxt;
    kick_s       akick_r, akick_nxt;
    logic [9:0]  aclim_r, aclim_nxt;
    logic        prof2_sel_r, prof2_sel_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic [8:0]  ds_r, ds_nxt;
    logic [9:0]  level_r, level_nxt;

    assign awready = !aw_got_r && !bvalid_r;
    assign wready  = !w_got_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    always_comb begin
        logic        aw_hs;
        logic        w_hs;
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic [31:0] m;
        aw_hs = awvalid && awready;
        w_hs  = wvalid && wready;
        wa    = aw_got_r ? awaddr_r : awaddr;
        wd    = w_got_r ? wdata_r : wdata;
        ws    = w_got_r ? wstrb_r : wstrb;
        m     = 32'h0000_0000;
        prof1_nxt  = prof1_r;
        prof2_nxt  = prof2_r;
        kick_nxt   = kick_r;
        clim_nxt   = clim_r;
        scale_nxt  = scale_r;
        dual_nxt   = dual_r;
        start_nxt  = 1'b0;
        stop_nxt   = 1'b0;
        aw_got_nxt = aw_got_r || aw_hs;
        w_got_nxt  = w_got_r || w_hs;
        awaddr_nxt = aw_hs ? awaddr : awaddr_r;
        wdata_nxt  = w_hs ? wdata : wdata_r;
        wstrb_nxt  = w_hs ? wstrb : wstrb_r;
        bvalid_nxt = bvalid_r && !bready;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r && !rready;
        rresp_nxt  = rresp_r;
        rdata_nxt  = rdata_r;
        line_nxt   = 26'(sense_in) * 26'(scale_r);
        // writes land in the setting registers; a start snapshots them
        if ((aw_got_r || aw_hs) && (w_got_r || w_hs)) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = RESP_OKAY;
            unique case (wa)
                CTRL_OFS: begin
                    m = merge({29'h0, dual_r, 2'h0}, wd, ws);
                    start_nxt = m[CTRL_START_BIT];
                    stop_nxt  = m[CTRL_STOP_BIT];
                    dual_nxt  = m[CTRL_DUAL_BIT];
                end
                PROF1_OFS: prof1_nxt = prof_wr(prof1_r, merge(prof_rd(prof1_r), wd, ws));
                PROF2_OFS: prof2_nxt = prof_wr(prof2_r, merge(prof_rd(prof2_r), wd, ws));
                CLIM_OFS: begin
                    m = merge({22'h0, clim_r}, wd, ws);
                    if (m[9:0] < CLIM_MIN_PCT) begin
                        clim_nxt = CLIM_MIN_PCT;
                    end else if (m[9:0] > CLIM_MAX_PCT) begin
                        clim_nxt = CLIM_MAX_PCT;
                    end else begin
                        clim_nxt = m[9:0];
                    end
                end
                KICK_OFS: begin
                    m = merge({17'h0, kick_r.level, 3'h0, kick_r.time_ds}, wd, ws);
                    kick_nxt.time_ds = (m[KICK_TIME_LSB +: 5] > KICK_MAX_DS) ? KICK_MAX_DS : m[KICK_TIME_LSB +: 5];
                    kick_nxt.level   = (m[KICK_LVL_LSB +: 7] > TORQ_MAX_PCT) ? TORQ_MAX_PCT : m[KICK_LVL_LSB +: 7];
                end
                SCALE_OFS: begin
                    m = merge({18'h0, scale_r}, wd, ws);
                    if (m[13:0] < SCALE_MIN) begin
                        scale_nxt = SCALE_MIN;
                    end else if (m[13:0] > SCALE_MAX) begin
                        scale_nxt = SCALE_MAX;
                    end else begin
                        scale_nxt = m[13:0];
                    end
                end
                OPTION_OFS, STATUS_OFS, LINE_OFS: bresp_nxt = RESP_SLVERR;
                default: bresp_nxt = RESP_DECERR;
            endcase
        end
        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            unique case (araddr)
                CTRL_OFS:   rdata_nxt = {29'h0, dual_r, 2'h0};
                PROF1_OFS:  rdata_nxt = prof_rd(prof1_r);
                PROF2_OFS:  rdata_nxt = prof_rd(prof2_r);
                CLIM_OFS:   rdata_nxt = {22'h0, clim_r};
                KICK_OFS:   rdata_nxt = {17'h0, kick_r.level, 3'h0, kick_r.time_ds};
                SCALE_OFS:  rdata_nxt = {18'h0, scale_r};
                STATUS_OFS: rdata_nxt = {14'h0, full_speed, prof2_sel_r, act_r.mode, level_r, 2'h0, state_r};
                OPTION_OFS: rdata_nxt = {24'h0, OPTION_CODE};
                LINE_OFS:   rdata_nxt = {6'h0, line_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_DECERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prof1_r  <= '{mode: MODE_SOFT, ramp_s: RAMP_RST, torque: 7'h00};
            prof2_r  <= '{mode: MODE_SOFT, ramp_s: RAMP_RST, torque: 7'h00};
            kick_r   <= '{time_ds: 5'h00, level: 7'h00};
            clim_r   <= CLIM_RST;
            scale_r  <= SCALE_RST;
            dual_r   <= 1'b0;
            start_r  <= 1'b0;
            stop_r   <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
            line_r   <= 26'h000_0000;
        end else begin
            prof1_r  <= prof1_nxt;
            prof2_r  <= prof2_nxt;
            kick_r   <= kick_nxt;
            clim_r   <= clim_nxt;
            scale_r  <= scale_nxt;
            dual_r   <= dual_nxt;
            start_r  <= start_nxt;
            stop_r   <= stop_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r  <= wdata_nxt;
            wstrb_r  <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r  <= rresp_nxt;
            rdata_r  <= rdata_nxt;
            line_r   <= line_nxt;
        end
    end

    // sequencer; one division per cycle is slow but the ramp only moves per tenth second
    always_comb begin
        logic       tenth;
        logic [8:0] total;
        logic [9:0] span;
        seq_state_e after_kick;
        state_nxt     = state_r;
        act_nxt       = act_r;
        akick_nxt     = akick_r;
        aclim_nxt     = aclim_r;
        prof2_sel_nxt = prof2_sel_r;
        tick_nxt      = (tick_r == 32'(TENTH_CYC - 1)) ? 32'h0 : tick_r + 32'h1;
        tenth         = (tick_r == 32'(TENTH_CYC - 1));
        ds_nxt        = ds_r;
        level_nxt     = level_r;
        total         = 9'(act_r.ramp_s * DS_PER_S);
        span          = FULL_PCT - {3'h0, act_r.torque};
        after_kick    = (act_r.mode == MODE_FULL || act_r.ramp_s == 5'h00) ? ST_FULL : ST_RAMP;
        unique case (state_r)
            ST_IDLE: begin
                level_nxt = 10'h000;
                if (start_r) begin
                    // settings snapshot here, so later writes wait for the next start
                    prof2_sel_nxt = dual_r && !select_hi;
                    act_nxt       = prof2_sel_nxt ? prof2_r : prof1_r;
                    akick_nxt     = kick_r;
                    aclim_nxt     = clim_r;
                    tick_nxt      = 32'h0;
                    ds_nxt        = 9'h000;
                    if (kick_r.time_ds != 5'h00 && act_nxt.mode != MODE_FULL) begin
                        state_nxt = ST_KICK;
                        level_nxt = {3'h0, kick_r.level};
                    end else if (act_nxt.mode == MODE_FULL || act_nxt.ramp_s == 5'h00) begin
                        state_nxt = ST_FULL;
                        level_nxt = FULL_PCT;
                    end else begin
                        state_nxt = ST_RAMP;
                        level_nxt = (act_nxt.mode == MODE_SOFT) ? {3'h0, act_nxt.torque} :
                                    (act_nxt.mode == MODE_CLIM) ? clim_r : 10'h000;
                    end
                end
            end
            ST_KICK: begin
                if (tenth) begin
                    ds_nxt = ds_r + 9'h1;
                    if (ds_nxt == {4'h0, akick_r.time_ds}) begin
                        ds_nxt    = 9'h000;
                        state_nxt = after_kick;
                        level_nxt = (after_kick == ST_FULL) ? FULL_PCT :
                                    (act_r.mode == MODE_SOFT) ? {3'h0, act_r.torque} :
                                    (act_r.mode == MODE_CLIM) ? aclim_r : 10'h000;
                    end
                end
            end
            ST_RAMP: begin
                if (full_speed && (act_r.mode == MODE_SOFT || act_r.mode == MODE_CLIM)) begin
                    state_nxt = ST_FULL;
                    level_nxt = FULL_PCT;
                end else if (tenth) begin
                    ds_nxt = ds_r + 9'h1;
                    if (ds_nxt >= total) begin
                        state_nxt = ST_FULL;
                        level_nxt = FULL_PCT;
                    end else if (act_r.mode == MODE_SOFT) begin
                        level_nxt = {3'h0, act_r.torque} + ramp_part(span, ds_nxt, total);
                    end else if (act_r.mode == MODE_SPEED) begin
                        level_nxt = ramp_part(FULL_PCT, ds_nxt, total);
                    end else begin
                        level_nxt = aclim_r;
                    end
                end
            end
            ST_FULL: level_nxt = FULL_PCT;
        endcase
        if (stop_r) begin
            state_nxt = ST_IDLE;
            level_nxt = 10'h000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= ST_IDLE;
            act_r       <= '{mode: MODE_SOFT, ramp_s: 5'h00, torque: 7'h00};
            akick_r     <= '{time_ds: 5'h00, level: 7'h00};
            aclim_r     <= CLIM_RST;
            prof2_sel_r <= 1'b0;
            tick_r      <= 32'h0;
            ds_r        <= 9'h000;
            level_r     <= 10'h000;
        end else begin
            state_r     <= state_nxt;
            act_r       <= act_nxt;
            akick_r     <= akick_nxt;
            aclim_r     <= aclim_nxt;
            prof2_sel_r <= prof2_sel_nxt;
            tick_r      <= tick_nxt;
            ds_r        <= ds_nxt;
            level_r     <= level_nxt;
        end
    end

    assign out_level    = level_r;
    assign out_mode     = act_r.mode;
    assign kick_active  = (state_r == ST_KICK);
    assign full_voltage = (state_r == ST_FULL);
    assign running      = (state_r != ST_IDLE);

endmodule // start_profile_seq

// ===== hdl/start_seq_pkg.sv
// Purpose: constants, types and register map for the motor start profile sequencer
// Assumes: 100 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes:   percent levels are whole percent, times are seconds or tenths of a second
package start_seq_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] PROF1_OFS  = 8'h04;
    localparam logic [7:0] PROF2_OFS  = 8'h08;
    localparam logic [7:0] CLIM_OFS   = 8'h0C;
    localparam logic [7:0] KICK_OFS   = 8'h10;
    localparam logic [7:0] SCALE_OFS  = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] OPTION_OFS = 8'h1C;
    localparam logic [7:0] LINE_OFS   = 8'h20;

    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT  = 1;
    localparam int CTRL_DUAL_BIT  = 2;
    localparam int PROF_MODE_LSB  = 0;
    localparam int PROF_RAMP_LSB  = 8;
    localparam int PROF_TORQ_LSB  = 16;
    localparam int KICK_TIME_LSB  = 0;
    localparam int KICK_LVL_LSB   = 8;

    // limits
    localparam logic [4:0]  RAMP_MAX_S   = 5'h1E;
    localparam logic [6:0]  TORQ_MAX_PCT = 7'h5A;
    localparam logic [9:0]  CLIM_MIN_PCT = 10'h032;
    localparam logic [9:0]  CLIM_MAX_PCT = 10'h258;
    localparam logic [4:0]  KICK_MAX_DS  = 5'h14;
    localparam logic [13:0] SCALE_MIN    = 14'h0001;
    localparam logic [13:0] SCALE_MAX    = 14'h2710;
    localparam logic [9:0]  FULL_PCT     = 10'h064;
    localparam logic [8:0]  DS_PER_S     = 9'h00A;

    // reset values
    localparam logic [9:0]  CLIM_RST  = 10'h15E;
    localparam logic [13:0] SCALE_RST = 14'h0001;
    localparam logic [4:0]  RAMP_RST  = 5'h0A;

    // timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TENTH_NS        = 100_000_000;
    localparam int TENTH_CYCLES    = TENTH_NS / CLK_PERIOD_NS;
    localparam int FULL_V_LIMIT_NS = 250_000_000;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        MODE_SOFT,
        MODE_CLIM,
        MODE_FULL,
        MODE_SPEED
    } start_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_KICK,
        ST_RAMP,
        ST_FULL
    } seq_state_e;

    typedef struct packed {
        start_mode_e mode;
        logic [4:0]  ramp_s;
        logic [6:0]  torque;
    } prof_s;

    typedef struct packed {
        logic [4:0] time_ds;
        logic [6:0] level;
    } kick_s;

endpackage

// ===== testbench/motor_tach_model.sv
// Purpose: motor, tachometer and profile contact facing the sequencer
// Assumes: motor reaches full speed ACCEL cycles after output starts
// Notes:   with fast low it never does, so every ramp runs its full time
`timescale 1ns/1ns
module motor_tach_model #(
    parameter int ACCEL = 150
) (
    // bench control
    input  wire logic        aclk,
    input  wire logic        fast,
    input  wire logic        sel_n,
    input  wire logic [11:0] volts,
    // sequencer side
    input  wire logic        running,
    output logic             full_speed_in,
    output logic             select_n_in,
    output logic [11:0]      sense_in
);
    int spd_r = 0;
    int spd_nxt;
    // speed decays to zero at once on stop so each start sees a standing motor
    always_comb spd_nxt = !running ? 0 : (spd_r < ACCEL ? spd_r + 1 : spd_r);
    always_ff @(posedge aclk) spd_r <= spd_nxt;
    assign full_speed_in = fast && spd_r == ACCEL;
    assign select_n_in   = sel_n;
    assign sense_in      = volts;
endmodule // motor_tach_model

// ===== testbench/start_seq_monitor.sv
// Purpose: port assertions for the start profile sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound into every sequencer instance
`timescale 1ns/1ns
module start_seq_monitor
    import start_seq_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // read handshake
    input wire logic        arready,
    input wire logic        rvalid,
    // motor side
    input wire logic        full_speed_in,
    input wire logic [9:0]  out_level,
    input wire start_mode_e out_mode,
    input wire logic        kick_active,
    input wire logic        full_voltage,
    input wire logic        running
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_FULL_LEVEL: assert property (full_voltage |-> out_level == FULL_PCT)
        else $error("full output level wrong");
    AST_KICK_LEVEL: assert property (kick_active |-> running && !full_voltage && out_level <= 10'h05A)
        else $error("kick level out of range");
    AST_CLIM_LEVEL: assert property (running && !kick_active && !full_voltage && out_mode == MODE_CLIM |-> out_level >= CLIM_MIN_PCT && out_level <= CLIM_MAX_PCT)
        else $error("limit level out of range");
    AST_SPEED_CUT: assert property ($rose(full_speed_in) && running && !kick_active && out_mode != MODE_SPEED |-> ##[1:6] full_voltage)
        else $error("full speed did not cut ramp");
    AST_FULL_FAST: assert property ($rose(running) |-> ##[0:3] (out_mode != MODE_FULL || full_voltage))
        else $error("full voltage start late");
    AST_KICK_FIRST: assert property ($rose(kick_active) |-> $rose(running))
        else $error("kick not at start");
    AST_FULL_STAYS: assert property (full_voltage && running |=> full_voltage || !running)
        else $error("full output dropped");
    AST_READ_BLOCK: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
endmodule // start_seq_monitor

bind start_profile_seq start_seq_monitor u_mon (.aclk, .aresetn, .arready, .rvalid, .full_speed_in,
    .out_level, .out_mode, .kick_active, .full_voltage, .running);

// ===== testbench/test_motor_start_profile_sequencer.sv
// Purpose: self-checking bench for the start profile sequencer
// Assumes: TENTH_CYC cut to 10 cycles; expected times scale from it
// Notes:   start times allow 3 cycles slack for pulse and sync latency
`timescale 1ns/1ns
module test_motor_start_profile_sequencer
    import start_seq_pkg::*;
;
    localparam int TC = 10;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        fast = 0, sel_n = 1, dual = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [11:0] volts = 0, sense_in;
    logic        awready, wready, bvalid, arready, rvalid, full_speed_in, select_n_in;
    logic        kick_active, full_voltage, running;
    logic [1:0]  bresp, rresp;
    logic [9:0]  out_level;
    start_mode_e out_mode;
    int          n_fail = 0, total_checks = 0, cyc = 0, seed = 58029, clim, sc;

    always #5 aclk = ~aclk;

    start_profile_seq #(.TENTH_CYC(TC)) uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
        .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .full_speed_in, .select_n_in, .sense_in,
        .out_level, .out_mode, .kick_active, .full_voltage, .running);
    motor_tach_model u_motor (.aclk, .fast, .sel_n, .volts, .running, .full_speed_in, .select_n_in, .sense_in);

    task automatic conclude();
        if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask

    function automatic int rnd(input int n);
        return $unsigned($random(seed)) % n;
    endfunction

    // kick is skipped in full voltage mode, so that start expects no delay
    function automatic int exp_time(input int m, r, k);
        return (m == 2) ? 0 : (k + r * 10) * TC;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        bready <= 1'h1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        rready  <= 1'h1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
        chk("rdata", e, rdata);
        chk("rresp", 32'((a > LINE_OFS) ? RESP_DECERR : RESP_OKAY), 32'(rresp));
    endtask

    task automatic seq(input logic [7:0] pa, input int m, r, t, k, l, input logic f);
        int   t0;
        int   dur;
        logic kseen = 0;
        logic rseen = 0;
        int   nc = 0;
        fast <= f;
        wr(KICK_OFS, 32'((l << 8) | k), RESP_OKAY);
        wr(pa, 32'((t << 16) | (r << 8) | m), RESP_OKAY);
        wr(CTRL_OFS, 32'((dual << 2) | 1), RESP_OKAY);
        t0 = cyc;
        while (!running && cyc < t0 + 10) @(posedge aclk);
        t0 = cyc;
        while (!full_voltage && cyc < t0 + 4000) begin
            if (kick_active) chk("kick level", 32'(l), 32'(out_level));
            if (!kick_active && !rseen && m < 2) begin
                rseen = 1;
                chk("start level", (m == 1) ? clim : t, 32'(out_level));
            end
            kseen |= kick_active;
            // a limit write during the kick must not reach this start
            if (kick_active && m == 1 && nc == 0) begin
                nc = 50 + rnd(551);
                wr(CLIM_OFS, 32'(nc), RESP_OKAY);
            end
            @(posedge aclk);
        end
        dur = cyc - t0;
        if (nc != 0) clim = nc;
        chk("mode", 32'(m), 32'(out_mode));
        chk("kick seen", 32'(k != 0 && m != 2), 32'(kseen));
        chk("full", 1, 32'(full_voltage));
        if (f) chk("early full", 1, 32'(dur < 300));
        else chk("start time", 1, 32'(dur <= exp_time(m, r, k) + 3 && dur + 3 >= exp_time(m, r, k)));
        rd(STATUS_OFS, {14'h0, f, pa == PROF2_OFS, 2'(m), FULL_PCT, 4'h3});
        wr(CTRL_OFS, 32'((dual << 2) | 2), RESP_OKAY);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(PROF1_OFS, 32'h00000A00);
        rd(CLIM_OFS, 32'(CLIM_RST));
        wr(OPTION_OFS, 32'hFF, RESP_SLVERR);
        rd(OPTION_OFS, 32'h00000001);
        wr(8'h40, 32'h0, RESP_DECERR);
        rd(8'h40, 32'h0);
        wr(CLIM_OFS, 32'h0A, RESP_OKAY);
        rd(CLIM_OFS, 32'(CLIM_MIN_PCT));
        wr(PROF1_OFS, 32'h00320A01, RESP_OKAY);
        rd(PROF1_OFS, 32'h00000A01);
        wr(SCALE_OFS, 32'h0, RESP_OKAY);
        rd(SCALE_OFS, 32'h1);
        sc = 1 + rnd(10000);
        volts <= 12'(rnd(4096));
        wr(SCALE_OFS, 32'(sc), RESP_OKAY);
        rd(LINE_OFS, 32'(volts) * 32'(sc));
        clim = 50 + rnd(551);
        wr(CLIM_OFS, 32'(clim), RESP_OKAY);
        for (int i = 0; i < 4; i++) seq(PROF1_OFS, i, 1 + rnd(3), rnd(91), rnd(21), rnd(91), 0);
        seq(PROF1_OFS, 1, 0, 0, 5, 40, 0);
        seq(PROF1_OFS, 1, 30, 0, 0, 0, 1);
        seq(PROF1_OFS, 0, 30, 20, 0, 0, 1);
        dual  <= 1'h1;
        sel_n <= 1'h0;
        wr(PROF1_OFS, 32'h00000A02, RESP_OKAY);
        seq(PROF2_OFS, 1, 1, 0, 20, 90, 0);
        sel_n <= 1'h1;
        wr(PROF2_OFS, 32'h00000A02, RESP_OKAY);
        seq(PROF1_OFS, 0, 2, 90, 3, 10, 0);
        conclude();
    end

    // a hang counts as a mismatch; the whole run needs well under 10000 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
endmodule // test_motor_start_profile_sequencer
